// ===== dv/pcec_cfg_master.sv
// config port master model: strobed accesses, split total reads.
// assumes rdy answers each strobe within four cycles.
`timescale 1ns/10ps
module pcec_cfg_master (
   input  wire logic        sys_clk_i,
   input  wire logic        rdy_i,
   input  wire logic [15:0] rdata_i,
   output logic             en_o,
   output logic             we_o,
   output logic [9:0]       addr_o
);
   initial begin
      en_o = 1'h0;
      we_o = 1'h0;
      addr_o = 10'h3FF;
   end
   task automatic acc(input logic w, input logic [9:0] a, output logic [15:0] d);
      d = 16'hXXXX;
      @(posedge sys_clk_i);
      en_o <= 1'h1;
      we_o <= w;
      addr_o <= a;
      @(posedge sys_clk_i);
      // one-cycle strobe: a held strobe would be taken as a second access
      en_o <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_i);
         if (rdy_i === 1'h1) begin
            d = rdata_i;
            break;
         end
      end
      addr_o <= ~a; // released bus must not keep the old address
   endtask : acc
   task automatic read_total(input logic alt, output logic [31:0] t);
      logic [15:0] lo;
      logic [15:0] hi;
      acc(1'h0, alt ? pcec_pkg::TOTAL_LOW_B_OFS : pcec_pkg::TOTAL_LOW_A_OFS, lo);
      acc(1'h0, alt ? pcec_pkg::TOTAL_HIGH_B_OFS : pcec_pkg::TOTAL_HIGH_A_OFS, hi);
      t = {hi, lo};
   endtask : read_total
endmodule : pcec_cfg_master

// ===== dv/pcec_chk.sv
// checker: port-level properties of pcec_checker_result.
// assumes one clock domain; ce_i qualifies every state change.
`timescale 1ns/10ps
module pcec_chk (
   input wire logic        sys_clk_i,
   input wire logic        rst_n_i,
   input wire logic        ce_i,
   input wire logic        word_valid_i,
   input wire logic [31:0] bit_mismatch_i,
   input wire logic        checker_counter_clear_i,
   input wire logic [7:0]  lock_acquire_threshold_i,
   input wire logic        error_feedback_select_i,
   input wire logic        tx_error_inject_i,
   input wire logic        checker_lock_flag_o,
   input wire logic        checker_error_pulse_o,
   input wire logic        tx_pattern_error_inject_o,
   input wire logic        threshold_unsupported_o,
   input wire logic        config_port_en_i,
   input wire logic        config_port_rdy_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_RDY_ANSWER: assert property (ce_i && config_port_en_i |=> config_port_rdy_o)
      else $error("no ready after access");
   AST_RDY_ONLY: assert property (ce_i && !config_port_en_i |=> !config_port_rdy_o)
      else $error("ready without access");
   AST_FEED_PULSE: assert property (error_feedback_select_i |->
      tx_pattern_error_inject_o == checker_error_pulse_o) else $error("inject not from pulse");
   AST_FEED_EXT: assert property (!error_feedback_select_i |->
      tx_pattern_error_inject_o == tx_error_inject_i) else $error("inject not external");
   AST_PULSE_CLEAN: assert property (ce_i && !(word_valid_i && |bit_mismatch_i)
      |=> !checker_error_pulse_o) else $error("pulse without bad word");
   AST_LOCK_HOLD: assert property (ce_i && checker_lock_flag_o && !checker_counter_clear_i
      |=> checker_lock_flag_o) else $error("lock dropped");
   AST_CLEAR_DROP: assert property (ce_i && checker_counter_clear_i
      |=> !checker_lock_flag_o) else $error("lock kept over clear");
   AST_LOCK_RISE: assert property ($rose(checker_lock_flag_o) |->
      $past(ce_i && word_valid_i && bit_mismatch_i == 32'h0)) else $error("lock on bad word");
   AST_THR_RANGE: assert property (threshold_unsupported_o ==
      (lock_acquire_threshold_i < pcec_pkg::THR_MIN)) else $error("threshold flag wrong");
endmodule : pcec_chk
bind pcec_checker_result pcec_chk u_chk (.sys_clk_i, .rst_n_i, .ce_i, .word_valid_i,
   .bit_mismatch_i, .checker_counter_clear_i, .lock_acquire_threshold_i,
   .error_feedback_select_i, .tx_error_inject_i, .checker_lock_flag_o, .checker_error_pulse_o,
   .tx_pattern_error_inject_o, .threshold_unsupported_o, .config_port_en_i, .config_port_rdy_o);

// ===== dv/tb.sv
// testbench: random checker stream and total reads on pcec_checker_result.
// assumes 50 MHz clock, pcec_cfg_master as config master, checker bound.
`timescale 1ns/10ps
module tb;
   logic sys_clk_i, rst_n_i, vld, clr, fb, inj, lock, pulse, txi, unsup, en, we, rdy, ce;
   logic [31:0] mm, exp_tot, got, b;
   logic [3:0] sel;
   logic [7:0] thr;
   logic [9:0] addr;
   logic [15:0] rdata, d;
   int n_mismatch = 0;
   int num_checks = 0;
   pcec_checker_result dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .word_valid_i(vld), .bit_mismatch_i(mm), .checker_pattern_select_i(sel),
      .checker_counter_clear_i(clr), .lock_acquire_threshold_i(thr),
      .error_feedback_select_i(fb), .tx_error_inject_i(inj), .checker_lock_flag_o(lock),
      .checker_error_pulse_o(pulse), .tx_pattern_error_inject_o(txi),
      .threshold_unsupported_o(unsup), .config_port_en_i(en), .config_port_we_i(we),
      .config_port_addr_i(addr), .config_port_rdata_o(rdata), .config_port_rdy_o(rdy));
   pcec_cfg_master m (.sys_clk_i(sys_clk_i), .rdy_i(rdy), .rdata_i(rdata), .en_o(en),
      .we_o(we), .addr_o(addr));
   function automatic logic [31:0] ones(input logic [31:0] v);
      logic [31:0] n;
      n = 32'h0;
      for (int i = 0; i < 32; i++) n = n + v[i];
      return n;
   endfunction : ones
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expct);
      num_checks++;
      if (seen !== expct) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, expct, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic word(input logic v, input logic [31:0] w, input logic [3:0] s, input logic c);
      @(posedge sys_clk_i);
      vld <= v;
      mm <= w;
      sel <= s;
      clr <= c;
      fb <= 1'($urandom);
      inj <= 1'($urandom);
   endtask : word
   initial begin
      sys_clk_i = 1'h0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      void'($urandom(2602));
      {rst_n_i, vld, clr, fb, inj, mm, sel, thr} = '0;
      ce = 1'h1;
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'h1;
      m.acc(1'h0, 10'h100, d);
      check("unmapped", {16'h0, d}, 32'h0);
      m.acc(1'h1, pcec_pkg::TOTAL_LOW_A_OFS, d);
      check("write", {16'h0, d}, 32'h0);
      thr <= 8'(15 + $urandom % 20);
      repeat (3) word(1'h1, 32'h0000_0100, 4'h1, 1'h0);
      repeat (thr - 3) word(1'h1, 32'h0, 4'h1, 1'h0);
      @(negedge sys_clk_i);
      check("early lock", lock, 1'h0);
      repeat (6) word(1'h1, 32'h0, 4'h1, 1'h0);
      @(negedge sys_clk_i);
      check("lock", lock, 1'h1);
      m.read_total(1'h0, got);
      check("total before lock", got, 32'h0);
      exp_tot = 32'h0;
      for (int i = 0; i < 24; i++) begin
         b = (i == 0) ? 32'h1 : (i == 1) ? 32'hFFFF_FFFF : ($urandom & $urandom) | 32'h1;
         word(i % 5 != 4, b, 4'(1 + $urandom % 5), 1'h0);
         word(1'h1, 32'h0, 4'h1, 1'h0);
         @(negedge sys_clk_i);
         check("pulse", pulse, i % 5 != 4);
         check("lock held", lock, 1'h1);
         if (i % 5 != 4) exp_tot = exp_tot + ones(b);
         if (i % 6 == 5) begin
            m.read_total(i[1], got);
            check("total", got, exp_tot);
         end
      end
      // frozen clock enable: neither the clear nor the bad word may act
      word(1'h1, 32'h0000_0007, 4'h1, 1'h1);
      ce <= 1'h0;
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check("pulse frozen", pulse, 1'h0);
      check("lock frozen", lock, 1'h1);
      word(1'h1, 32'h0, 4'h1, 1'h0);
      ce <= 1'h1;
      word(1'h1, 32'h0000_00F0, 4'hA, 1'h0);
      word(1'h1, 32'h0000_00F0, 4'h0, 1'h0);
      @(negedge sys_clk_i);
      check("pulse bad sel", pulse, 1'h0);
      word(1'h1, 32'h0, 4'h0, 1'h0);
      @(negedge sys_clk_i);
      check("pulse off", pulse, 1'h0);
      m.read_total(1'h0, got);
      check("total off", got, exp_tot);
      word(1'h1, 32'h0000_000F, 4'h1, 1'h1);
      word(1'h1, 32'h0, 4'h1, 1'h0);
      @(negedge sys_clk_i);
      check("lock cleared", lock, 1'h0);
      m.read_total(1'h1, got);
      check("total cleared", got, 32'h0);
      give_verdict();
   end
endmodule : tb

// ===== include/pcec_pkg.sv
// pcec_pkg: constants shared by the pattern checker result logic.
// assumes one 50 MHz clock domain and a 16-bit configuration port.
package pcec_pkg;

   localparam int unsigned DATA_W        = 32;
   localparam int unsigned CNT_W         = 32;
   localparam int unsigned CFG_ADDR_W    = 10;
   localparam int unsigned CFG_DATA_W    = 16;
   localparam int unsigned SEL_W         = 4;
   localparam int unsigned THR_W         = 8;

   // configuration port offsets of the error total halves
   localparam logic [9:0]  TOTAL_LOW_A_OFS  = 10'h15E;
   localparam logic [9:0]  TOTAL_HIGH_A_OFS = 10'h15F;
   localparam logic [9:0]  TOTAL_LOW_B_OFS  = 10'h25E;
   localparam logic [9:0]  TOTAL_HIGH_B_OFS = 10'h25F;

   // field positions inside the 32-bit total
   localparam int unsigned LOW_LSB       = 0;
   localparam int unsigned HIGH_LSB      = 16;

   // reset and saturation values
   localparam logic [31:0] TOTAL_RST     = 32'h0000_0000;
   localparam logic [31:0] TOTAL_SAT     = 32'hFFFF_FFFF;
   localparam logic [15:0] HOLD_RST      = 16'h0000;
   localparam logic [15:0] RDATA_RST     = 16'h0000;
   localparam logic [7:0]  RUN_RST       = 8'h00;

   // pattern select codes
   localparam logic [3:0]  SEL_OFF       = 4'h0;
   localparam logic [3:0]  SEL_SEQ7      = 4'h1;
   localparam logic [3:0]  SEL_SEQ9      = 4'h2;
   localparam logic [3:0]  SEL_SEQ15     = 4'h3;
   localparam logic [3:0]  SEL_SEQ23     = 4'h4;
   localparam logic [3:0]  SEL_SEQ31     = 4'h5;

   // supported lock threshold range
   localparam logic [7:0]  THR_MIN       = 8'h0F;
   localparam logic [7:0]  THR_MAX       = 8'hFF;

   typedef enum logic [1:0] {
      PCEC_OFF    = 2'b00,
      PCEC_HUNT   = 2'b01,
      PCEC_LOCKED = 2'b10
   } pcec_state_e;

   // number of set bits in a mismatch word
   function automatic logic [5:0] pcec_popcount(input logic [DATA_W-1:0] v);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < DATA_W; i++) begin
         n = n + {5'h00, v[i]};
      end
      return n;
   endfunction : pcec_popcount

   // true for the five defined sequence codes
   function automatic logic pcec_sel_valid(input logic [3:0] sel);
      return (sel >= SEL_SEQ7) && (sel <= SEL_SEQ31);
   endfunction : pcec_sel_valid

endpackage : pcec_pkg

// ===== src/pcec_checker_result.sv
// pcec_checker_result: error total, lock flag, error pulse and feedback
// of the receive pattern checker, with the total read over the config port.
// assumes the comparator upstream supplies a per-bit mismatch word and
// all inputs are synchronous to sys_clk_i.
//
// Behaviour
// - a counter clear sets the 32-bit error total to zero.
// - one mismatching bit adds one to the total.
// - a word with several bad bits adds its exact bad-bit count.
// - nothing is added to the total until the lock flag has risen.
// - the total saturates at all ones and never wraps.
// - the total is read only as two 16-bit config port reads.
// - with feedback select 1 the error pulse drives the tx inject.
// - with feedback select 0 the external inject drives the tx inject.
// - lock rises after the programmed count of error-free valid words.
// - select 0 is off, 1 to 5 pick the 7/9/15/23/31 stage sequences.
// - once high the lock flag stays high until reset or clear.
// - the error pulse is high only in cycles with errors, not sticky.
`timescale 1ns/10ps
module pcec_checker_result (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   // checker datapath side
   input  wire logic        word_valid_i,
   input  wire logic [31:0] bit_mismatch_i,
   input  wire logic [3:0]  checker_pattern_select_i,
   input  wire logic        checker_counter_clear_i,
   input  wire logic [7:0]  lock_acquire_threshold_i,
   input  wire logic        error_feedback_select_i,
   input  wire logic        tx_error_inject_i,
   output logic             checker_lock_flag_o,
   output logic             checker_error_pulse_o,
   output logic             tx_pattern_error_inject_o,
   output logic             threshold_unsupported_o,
   // configuration port
   input  wire logic        config_port_en_i,
   input  wire logic        config_port_we_i,
   input  wire logic [9:0]  config_port_addr_i,
   output logic      [15:0] config_port_rdata_o,
   output logic             config_port_rdy_o
);

   pcec_pkg::pcec_state_e state_reg;
   pcec_pkg::pcec_state_e state_next;
   logic [7:0]            run_reg;
   logic [7:0]            run_next;
   logic                  err_reg;
   logic                  err_next;
   logic [15:0]           hold_reg;
   logic [15:0]           hold_next;
   logic [15:0]           rdata_reg;
   logic [15:0]           rdata_next;
   logic                  rdy_reg;
   logic                  rdy_next;
   logic [31:0]           total;
   logic                  active;
   logic                  word_bad;
   logic                  add_en;
   logic [5:0]            bad_bits;
   logic [7:0]            run_inc;

   // checking only runs for a defined sequence code
   assign active   = pcec_pkg::pcec_sel_valid(checker_pattern_select_i);
   assign word_bad = active && word_valid_i && (bit_mismatch_i != 32'h0000_0000);
   assign bad_bits = pcec_pkg::pcec_popcount(bit_mismatch_i);
   assign run_inc  = run_reg + 8'h01;

   // ---- lock tracking ----
   always_comb begin
      state_next = state_reg;
      run_next   = run_reg;
      if (checker_counter_clear_i) begin
         // clear restarts the hunt for lock
         state_next = pcec_pkg::PCEC_OFF;
         run_next   = pcec_pkg::RUN_RST;
      end else begin
         case (state_reg)
            pcec_pkg::PCEC_OFF: begin
               // run stays at zero until a sequence is selected
               run_next = pcec_pkg::RUN_RST;
               if (active) begin
                  state_next = pcec_pkg::PCEC_HUNT;
               end
            end
            pcec_pkg::PCEC_HUNT: begin
               if (!active) begin
                  state_next = pcec_pkg::PCEC_OFF;
                  run_next   = pcec_pkg::RUN_RST;
               end else if (word_bad) begin
                  run_next = pcec_pkg::RUN_RST;
               end else if (word_valid_i) begin
                  // threshold compare on the incremented run length
                  // invalid cycles neither advance nor reset the run
                  // no wrap: the top threshold of 255 locks first
                  if (run_inc >= lock_acquire_threshold_i) begin
                     state_next = pcec_pkg::PCEC_LOCKED;
                  end
                  run_next = run_inc;
               end
            end
            pcec_pkg::PCEC_LOCKED: begin
               // sticky: pattern changes do not drop lock
               state_next = pcec_pkg::PCEC_LOCKED;
            end
            default: begin
               state_next = pcec_pkg::PCEC_OFF;
               run_next   = pcec_pkg::RUN_RST;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= pcec_pkg::PCEC_OFF;
         run_reg   <= pcec_pkg::RUN_RST;
      end else if (ce_i) begin
         state_reg <= state_next;
         run_reg   <= run_next;
      end
   end

   assign checker_lock_flag_o = (state_reg == pcec_pkg::PCEC_LOCKED);

   // out-of-range thresholds are flagged, not corrected; lock still works
   always_comb begin
      threshold_unsupported_o = 1'b0;
      if (lock_acquire_threshold_i < pcec_pkg::THR_MIN) begin
         threshold_unsupported_o = 1'b1;
      end
   end

   // ---- error pulse ----
   // registered so the tx inject sees a clean one-cycle pulse
   always_comb begin
      err_next = word_bad;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_reg <= 1'b0;
      end else if (ce_i) begin
         err_reg <= err_next;
      end
   end

   assign checker_error_pulse_o = err_reg;

   // feedback mux stays in this clock domain, so no crossing is needed
   always_comb begin
      if (error_feedback_select_i) begin
         tx_pattern_error_inject_o = err_reg;
      end else begin
         tx_pattern_error_inject_o = tx_error_inject_i;
      end
   end

   // ---- error total ----
   // counting only while locked; the locking word itself is error free
   // clear wins over a same-cycle error add inside the accumulator
   assign add_en = word_bad && (state_reg == pcec_pkg::PCEC_LOCKED);

   pcec_err_accum u_accum (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .clear_i    (checker_counter_clear_i),
      .add_en_i   (add_en),
      .add_bits_i (bad_bits),
      .total_o    (total)
   );

   // ---- configuration port reads ----
   always_comb begin
      hold_next  = hold_reg;
      rdata_next = rdata_reg;
      rdy_next   = 1'b0;
      if (config_port_en_i) begin
         rdy_next = 1'b1;
         // writes are acknowledged but change nothing: the total is read only
         if (!config_port_we_i) begin
            case (config_port_addr_i)
               pcec_pkg::TOTAL_LOW_A_OFS,
               pcec_pkg::TOTAL_LOW_B_OFS: begin
                  rdata_next = total[pcec_pkg::LOW_LSB +: 16];
                  // snapshot so the pair reads one consistent value
                  hold_next  = total[pcec_pkg::HIGH_LSB +: 16];
               end
               pcec_pkg::TOTAL_HIGH_A_OFS,
               pcec_pkg::TOTAL_HIGH_B_OFS: begin
                  rdata_next = hold_reg;
               end
               default: begin
                  // unmapped reads return zero, never stale data
                  rdata_next = pcec_pkg::RDATA_RST;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_reg  <= pcec_pkg::HOLD_RST;
         rdata_reg <= pcec_pkg::RDATA_RST;
         rdy_reg   <= 1'b0;
      end else if (ce_i) begin
         hold_reg  <= hold_next;
         rdata_reg <= rdata_next;
         rdy_reg   <= rdy_next;
      end
   end

   assign config_port_rdata_o = rdata_reg;
   assign config_port_rdy_o   = rdy_reg;

endmodule : pcec_checker_result

// ===== src/pcec_err_accum.sv
// pcec_err_accum: saturating 32-bit bit-error accumulator.
// assumes clear and add inputs synchronous to sys_clk_i.
`timescale 1ns/10ps
module pcec_err_accum (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        clear_i,
   input  wire logic        add_en_i,
   input  wire logic [5:0]  add_bits_i,
   output logic      [31:0] total_o
);

   logic [31:0] total_reg;
   logic [31:0] total_next;
   logic [32:0] sum;

   always_comb begin
      sum        = {1'b0, total_reg} + {27'h0000000, add_bits_i};
      total_next = total_reg;
      if (clear_i) begin
         total_next = pcec_pkg::TOTAL_RST;
      end else if (add_en_i) begin
         // carry out means the total passed all ones
         if (sum[32]) begin
            total_next = pcec_pkg::TOTAL_SAT;
         end else begin
            total_next = sum[31:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         total_reg <= pcec_pkg::TOTAL_RST;
      end else if (ce_i) begin
         total_reg <= total_next;
      end
   end

   assign total_o = total_reg;

endmodule : pcec_err_accum
